// file: spsp_top.v
// Serial configuration port: frames from the host are sampled on clk_sys_in,
// each received byte with a target nibble of 0h to 9h is decoded into holding, pointer, command or mode writes.
// Assumes cs_n_in stays high for several system clocks between frames and that
// the serial clock is much slower than clk_sys_in.
// Holds no busy flag: the host keeps the flash program wait itself.
`timescale 1ns/10ps
`include "spsp_map.vh"
module spsp_top (
   input  wire        clk_sys_in,
   input  wire        nrst_in,
   input  wire        cs_n_in,
   input  wire        sclk_in,
   input  wire        di_in,
   output wire        do_out,
   output reg         do_oe_out,
   output reg         four_wire_out,
   output reg         flash_write_power_enable_out,
   output reg         port_wr_out,
   output reg  [15:0] port_addr_out,
   output reg  [15:0] port_data_out
);
   localparam ST_IDLE   = 2'b00;
   localparam ST_DECODE = 2'b01;
   localparam ST_FLWAIT = 2'b10;
   localparam ST_FLLOAD = 2'b11;

   reg         rst_meta_reg;
   reg         rst_n_reg;
   wire [2:0]  pins_sync;
   wire        cs_n_s;
   wire        sclk_s;
   wire        di_s;
   reg         cs_n_d_reg;
   reg         sclk_d_reg;
   reg  [7:0]  shift_reg;
   reg  [3:0]  bit_cnt_reg;
   reg  [15:0] out_shift_reg;
   reg         out_frame_reg;
   reg         arm_reg;
   reg  [7:0]  input_byte_latch_reg;
   reg  [1:0]  state_reg;
   reg  [15:0] transfer_holding_word_reg;
   reg  [15:0] port_flash_pointer_reg;
   reg  [3:0]  command_nibble_reg;
   reg  [3:0]  interface_mode_nibble_reg;
   reg         flash_rd_reg;
   reg         flash_wr_reg;
   wire [7:0]  flash_rdata;
   wire        cs_fall;
   wire        cs_rise;
   wire        sclk_rise;
   wire        sclk_fall;
   wire [3:0]  target_select_nibble;
   wire [3:0]  payload_nibble;
   wire        byte_done;

   // Release of the asynchronous reset goes through two flops.
   // Every other flop with a reset uses the released copy, so all leave reset on one edge.
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   spsp_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_in   (clk_sys_in),
      .rst_n_in (rst_n_reg),
      .async_in ({cs_n_in, sclk_in, di_in}),
      .sync_out (pins_sync)
   );

   assign cs_n_s    = pins_sync[2];
   assign sclk_s    = pins_sync[1];
   assign di_s      = pins_sync[0];
   assign cs_fall   = cs_n_d_reg & ~cs_n_s;
   assign cs_rise   = ~cs_n_d_reg & cs_n_s;
   // clock edges count only while selected
   // Edges outside a frame are dropped, so a free-running serial clock is harmless.
   assign sclk_rise = ~cs_n_s & ~sclk_d_reg & sclk_s;
   assign sclk_fall = ~cs_n_s & sclk_d_reg & ~sclk_s;

   assign target_select_nibble = input_byte_latch_reg[3:0];
   assign payload_nibble       = input_byte_latch_reg[7:4];

   // full byte test
   // A long 4-wire frame saturates the counter at eight, so it still counts as one byte.
   assign byte_done = cs_rise & (bit_cnt_reg == `SPSP_BYTE_BITS) & ~out_frame_reg;

   // output shifts straight from the holding copy
   // The value on do_out only means something while do_oe_out is high.
   assign do_out = out_shift_reg[15];

   // Flash contents start unknown and no erase is modelled, so a program
   // command simply overwrites the addressed byte.
   spsp_flash_mem u_flash (
      .clk_in    (clk_sys_in),
      .rd_en_in  (flash_rd_reg),
      .wr_en_in  (flash_wr_reg),
      .addr_in   (port_flash_pointer_reg[`SPSP_FLASH_AW-1:0]),
      .wdata_in  (transfer_holding_word_reg[7:0]),
      .rdata_out (flash_rdata)
   );

   // Serial side of the frame: shifting, counting, output drive.
   // no halt or run state gates this logic
   always @(posedge clk_sys_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cs_n_d_reg           <= 1'b1;
         // The synchroniser comes out of reset high; matching it here keeps
         // reset from looking like a serial clock edge.
         sclk_d_reg           <= 1'b1;
         shift_reg            <= 8'h00;
         bit_cnt_reg          <= 4'h0;
         out_shift_reg        <= 16'h0000;
         out_frame_reg        <= 1'b0;
         do_oe_out            <= 1'b0;
         input_byte_latch_reg <= 8'h00;
      end else begin
         cs_n_d_reg <= cs_n_s;
         sclk_d_reg <= sclk_s;
         if (cs_fall) begin
            bit_cnt_reg   <= 4'h0;
            // The first output bit is presented at the select edge, before any clock pulse.
            out_shift_reg <= transfer_holding_word_reg;
            // drive only in 4-wire or an armed frame
            do_oe_out     <= four_wire_out | arm_reg;
            out_frame_reg <= ~four_wire_out & arm_reg;
         end
         // lsb first, keep only the last eight bits
         if (sclk_rise) begin
            shift_reg <= {di_s, shift_reg[7:1]};
            if (bit_cnt_reg != `SPSP_BYTE_BITS) begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end
         // msb first, next bit on each falling edge
         if (sclk_fall) begin
            out_shift_reg <= {out_shift_reg[14:0], 1'b0};
         end
         if (cs_rise) begin
            // output off again when the frame ends
            // In 4-wire mode it turns on again at the next select edge.
            do_oe_out     <= 1'b0;
            out_frame_reg <= 1'b0;
            // latch only full bytes, and never the 3-wire read frame
            if (byte_done) begin
               input_byte_latch_reg <= shift_reg;
            end
         end
      end
   end

   // Decode and execution of latched bytes, a few system clocks per command.
   // every non-flash command is done within four system clocks
   // Flash program takes one clock here; the host owns the long program wait.
   always @(posedge clk_sys_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg                    <= ST_IDLE;
         four_wire_out                <= 1'b0;
         arm_reg                      <= 1'b0;
         transfer_holding_word_reg    <= `SPSP_HOLD_RESET;
         port_flash_pointer_reg       <= `SPSP_PTR_RESET;
         command_nibble_reg           <= 4'h0;
         interface_mode_nibble_reg    <= 4'h0;
         flash_rd_reg                 <= 1'b0;
         flash_wr_reg                 <= 1'b0;
         flash_write_power_enable_out <= 1'b0;
         port_wr_out                  <= 1'b0;
         port_addr_out                <= 16'h0000;
         port_data_out                <= 16'h0000;
      end else begin
         flash_rd_reg <= 1'b0;
         flash_wr_reg <= 1'b0;
         port_wr_out  <= 1'b0;
         // the armed frame consumes the enable
         // A 19h decoded in the same clock is assigned later and so wins.
         if (cs_rise && out_frame_reg) begin
            arm_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               // A byte ending in a flash read wait would be lost; frame length rules it out.
               if (byte_done) begin
                  state_reg <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               state_reg <= ST_IDLE;
               if (target_select_nibble <= `SPSP_TGT_HOLD_HI) begin
                  transfer_holding_word_reg[target_select_nibble[1:0]*4 +: 4]
                     <= payload_nibble;
               end else if (target_select_nibble <= `SPSP_TGT_PTR_HI) begin
                  port_flash_pointer_reg[target_select_nibble[1:0]*4 +: 4]
                     <= payload_nibble;
               end else if (target_select_nibble == `SPSP_TGT_COMMAND) begin
                  command_nibble_reg <= payload_nibble;
                  case (payload_nibble)
                     `SPSP_CMD_PORT_WR: begin
                        if (port_flash_pointer_reg[3:0] == `SPSP_PORT_DATA) begin
                           port_data_out <= transfer_holding_word_reg;
                        end else if (port_flash_pointer_reg[3:0] == `SPSP_PORT_ADDR) begin
                           port_addr_out <= transfer_holding_word_reg;
                        end else if (port_flash_pointer_reg[3:0] == `SPSP_PORT_STROBE &&
                                     transfer_holding_word_reg[`SPSP_PORT_GO_BIT]) begin
                           port_wr_out <= 1'b1;
                           // Only the flash write bit of the power word is kept.
                           if (port_addr_out == `SPSP_POWER_ADDR) begin
                              flash_write_power_enable_out
                                 <= port_data_out[`SPSP_POWER_FLWR_BIT];
                           end
                        end
                     end
                     `SPSP_CMD_FLASH_WR: begin
                        flash_wr_reg <= flash_write_power_enable_out;
                     end
                     // flash byte into the holding word
                     `SPSP_CMD_FLASH_RD: begin
                        flash_rd_reg <= 1'b1;
                        state_reg    <= ST_FLWAIT;
                     end
                     // reset clears the write power enable
                     `SPSP_CMD_RESET: begin
                        flash_write_power_enable_out <= 1'b0;
                        transfer_holding_word_reg    <= `SPSP_HOLD_RESET;
                        port_flash_pointer_reg       <= `SPSP_PTR_RESET;
                        port_addr_out                <= 16'h0000;
                        port_data_out                <= 16'h0000;
                     end
                     // Erase, halt and partition commands are not supported.
                     default: begin
                        command_nibble_reg <= payload_nibble;
                     end
                  endcase
               end else if (target_select_nibble == `SPSP_TGT_MODE) begin
                  interface_mode_nibble_reg <= payload_nibble;
                  // Other mode nibbles are stored but change nothing.
                  // 09h selects 4-wire
                  if (payload_nibble == `SPSP_MODE_FOUR_WIRE) begin
                     four_wire_out <= 1'b1;
                     arm_reg       <= 1'b0;
                  end else if (payload_nibble == `SPSP_MODE_THREE_EN) begin
                     // 19h arms one output frame in 3-wire
                     four_wire_out <= 1'b0;
                     arm_reg       <= 1'b1;
                  end
               end
            end
            ST_FLWAIT: begin
               state_reg <= ST_FLLOAD;
            end
            ST_FLLOAD: begin
               // flash data lands in the low byte
               // The memory answers one clock after its strobe, hence the wait state.
               transfer_holding_word_reg <= {8'h00, flash_rdata};
               state_reg                 <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// file: spsp_map.vh
// Constants of the sensor processor serial port: target codes, command nibbles,
// mode nibbles, port pointer codes and reset values.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SPSP_MAP_VH
`define SPSP_MAP_VH

`define SPSP_BYTE_BITS      4'h8
`define SPSP_TGT_HOLD_HI    4'h3
`define SPSP_TGT_PTR_LO     4'h4
`define SPSP_TGT_PTR_HI     4'h7
`define SPSP_TGT_COMMAND    4'h8
`define SPSP_TGT_MODE       4'h9

`define SPSP_CMD_PORT_WR    4'h0
`define SPSP_CMD_FLASH_WR   4'h1
`define SPSP_CMD_FLASH_RD   4'h3
`define SPSP_CMD_RESET      4'hb

`define SPSP_MODE_FOUR_WIRE 4'h0
`define SPSP_MODE_THREE_EN  4'h1

`define SPSP_PORT_DATA      4'hd
`define SPSP_PORT_ADDR      4'he
`define SPSP_PORT_STROBE    4'hf
`define SPSP_PORT_GO_BIT    15
`define SPSP_POWER_ADDR     16'h0031
`define SPSP_POWER_FLWR_BIT 12

`define SPSP_HOLD_RESET     16'h0000
`define SPSP_PTR_RESET      16'h0000
`define SPSP_FLASH_AW       12

`endif

// file: spsp_sync.v
// Two-flop synchroniser for a group of independent asynchronous levels.
// Assumes each bit is a slow level or an edge that lasts several clocks.
`timescale 1ns/10ps
module spsp_sync #(
   parameter WIDTH = 3
) (
   input  wire             clk_in,
   input  wire             rst_n_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// file: spsp_flash_mem.v
// Byte-wide program memory behind the serial port, reads and writes share one address.
// Assumes the caller never reads and writes the same byte in one cycle.
`timescale 1ns/10ps
`include "spsp_map.vh"
module spsp_flash_mem (
   input  wire                      clk_in,
   input  wire                      rd_en_in,
   input  wire                      wr_en_in,
   input  wire [`SPSP_FLASH_AW-1:0] addr_in,
   input  wire [7:0]                wdata_in,
   output reg  [7:0]                rdata_out
);
   reg [7:0] mem [0:(1<<`SPSP_FLASH_AW)-1];

   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[addr_in] <= wdata_in;
      end
      if (rd_en_in) begin
         rdata_out <= mem[addr_in];
      end
   end
endmodule

// file: spsp_top_asserts.sv
// Concurrent checks on the ports of the serial configuration port.
// Assumes it is bound to spsp_top and that nrst_in is the raw reset.
`timescale 1ns/10ps
module spsp_top_asserts (
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic        cs_n_in,
   input wire logic        sclk_in,
   input wire logic        di_in,
   input wire logic        do_out,
   input wire logic        do_oe_out,
   input wire logic        four_wire_out,
   input wire logic        flash_write_power_enable_out,
   input wire logic        port_wr_out,
   input wire logic [15:0] port_addr_out,
   input wire logic [15:0] port_data_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   oe_idle_off_a: assert property (cs_n_in [*6] |-> !do_oe_out)
      else $error("data out enabled while deselected");
   oe_four_on_a: assert property ((four_wire_out && !cs_n_in) [*6] |-> do_oe_out)
      else $error("data out not enabled in four wire frame");
   oe_rise_sel_a: assert property ($rose(do_oe_out) |-> !cs_n_in && $past(!cs_n_in))
      else $error("data out enabled outside a frame");
   wr_pulse_a: assert property (port_wr_out |=> !port_wr_out)
      else $error("port write strobe longer than one cycle");
   wr_deselect_a: assert property (port_wr_out |-> cs_n_in && $past(cs_n_in, 2))
      else $error("port write before chip select rose");
   mode_deselect_a: assert property ($changed(four_wire_out) |-> cs_n_in)
      else $error("mode changed inside a frame");
   power_rise_a: assert property ($rose(flash_write_power_enable_out)
      |-> port_addr_out == 16'h0031 && port_data_out[12])
      else $error("power bit set without port write");
   port_regs_a: assert property ($changed(port_addr_out) || $changed(port_data_out) |-> cs_n_in)
      else $error("port registers changed inside a frame");
   do_hold_a: assert property (sclk_in [*4] |-> $stable(do_out))
      else $error("data out moved while serial clock high");
   cover property ($rose(do_oe_out) && !four_wire_out);
   cover property (port_wr_out);
   cover property ($fell(flash_write_power_enable_out));
   cover property ($rose(four_wire_out));
endmodule

// file: spsp_host_model.sv
// Behavioural calibration host driving chip select, serial clock and data in.
// Assumes dio_in is the resolved data out line; serial clock idles low.
`timescale 1ns/10ps
module spsp_host_model (
   input  wire logic clk_in,
   input  wire logic dio_in,
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      di_out
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      di_out   = 1'b0;
   end
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      #64;
      for (int i = 0; i < nbits; i++) begin
         di_out = tx[i];
         #32 sclk_out = 1'b1;
         rx = {rx[14:0], dio_in};
         #32 sclk_out = 1'b0;
      end
      // Released data line shows the inverse so a stale bit cannot pass.
      #32 di_out = ~di_out;
      cs_n_out = 1'b1;
      #200;
   endtask
   task automatic send(input logic [7:0] b);
      logic [15:0] rx;
      frame({8'h00, b}, 8, rx);
   endtask
   task automatic load16(input logic [3:0] base, input logic [15:0] v);
      for (int k = 0; k < 4; k++) send({v[4*k+:4], base + k[3:0]});
   endtask
   task automatic flash_wr();
      send(8'h18);
      #80000;
   endtask
endmodule

// file: test_sensor_processor_serial_port.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model above and the checker bound below.
`timescale 1ns/10ps
module test_sensor_processor_serial_port;
   logic        clk_sys_in = 1'b0;
   logic        nrst_in = 1'b0;
   wire         cs_n, sclk, di;
   wire         do_out, do_oe_out, four_wire, pwr, port_wr;
   wire  [15:0] port_addr, port_data;
   wire         dio = do_oe_out ? do_out : 1'bz;
   int          err_total = 0;
   int          comparisons = 0;
   int          wr_cnt = 0;
   int          oe_cnt = 0;
   initial forever #2.5 clk_sys_in = ~clk_sys_in;
   spsp_top u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .sclk_in(sclk),
      .di_in(di), .do_out(do_out), .do_oe_out(do_oe_out), .four_wire_out(four_wire),
      .flash_write_power_enable_out(pwr), .port_wr_out(port_wr),
      .port_addr_out(port_addr), .port_data_out(port_data));
   spsp_host_model u_host (.clk_in(clk_sys_in), .dio_in(dio), .cs_n_out(cs_n),
      .sclk_out(sclk), .di_out(di));
   // Counters are only read by the tests, which compare against a snapshot.
   always @(posedge clk_sys_in) begin
      if (do_oe_out === 1'b1) oe_cnt <= oe_cnt + 1;
      if (port_wr === 1'b1) wr_cnt <= wr_cnt + 1;
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd4(input logic [7:0] b, output logic [15:0] v);
      u_host.frame({b, 8'h00}, 16, v);
   endtask
   task automatic t_reset;
      chk("four_wire", 16'h0000, four_wire);
      chk("oe", 16'h0000, do_oe_out);
      chk("power", 16'h0000, pwr);
      chk("port_addr", 16'h0000, port_addr);
      $display("test reset done");
   endtask
   task automatic t_three;
      logic [15:0] v;
      int          base;
      base = oe_cnt;
      u_host.load16(4'h0, 16'ha5c3);
      chk("oe_unarmed", 16'h0000, oe_cnt != base);
      u_host.send(8'h19);
      u_host.frame(16'h5555, 16, v);
      chk("read_3w", 16'ha5c3, v);
      chk("oe_armed", 16'h0001, oe_cnt != base);
      base = oe_cnt;
      u_host.frame(16'h0500, 16, v);
      chk("oe_after", 16'h0000, oe_cnt != base);
      $display("test three wire done");
   endtask
   task automatic t_port;
      int wr_base;
      wr_base = wr_cnt;
      u_host.load16(4'h0, 16'h1000);
      u_host.send(8'hd4);
      u_host.send(8'h08);
      u_host.load16(4'h0, 16'h0031);
      u_host.send(8'he4);
      u_host.send(8'h08);
      u_host.load16(4'h0, 16'h8000);
      u_host.send(8'hf4);
      chk("power_early", 16'h0000, pwr);
      u_host.send(8'h08);
      chk("wr_cnt", 16'h0001, 16'(wr_cnt - wr_base));
      chk("power", 16'h0001, pwr);
      chk("port_addr", 16'h0031, port_addr);
      chk("port_data", 16'h1000, port_data);
      $display("test port write done");
   endtask
   task automatic t_flash;
      logic [15:0] v;
      u_host.load16(4'h4, 16'h0012);
      u_host.load16(4'h0, 16'h005a);
      u_host.flash_wr();
      u_host.load16(4'h0, 16'hffff);
      u_host.send(8'h38);
      u_host.send(8'h09);
      chk("four_wire", 16'h0001, four_wire);
      rd4(8'h71, v);
      chk("flash_read", 16'h005a, v);
      rd4(8'h09, v);
      chk("read_4w", 16'h007a, v);
      // Decoded by mistake, these seven bits would set holding nibble 2 to fh.
      u_host.frame(16'h0079, 7, v);
      rd4(8'h09, v);
      chk("short_frame", 16'h007a, v);
      $display("test flash done");
   endtask
   task automatic t_reset_cmd;
      logic [15:0] v;
      u_host.send(8'hb8);
      chk("power", 16'h0000, pwr);
      chk("port_data", 16'h0000, port_data);
      chk("port_addr", 16'h0000, port_addr);
      chk("four_wire", 16'h0001, four_wire);
      rd4(8'h09, v);
      chk("hold_cleared", 16'h0000, v);
      u_host.send(8'h19);
      chk("back_to_3w", 16'h0000, four_wire);
      $display("test reset command done");
   endtask
   // The block is left armed by the last test, so reset must drop the armed frame.
   task automatic t_midreset;
      logic [15:0] v;
      int          base;
      @(negedge clk_sys_in);
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk("four_wire_rst", 16'h0000, four_wire);
      chk("oe_rst", 16'h0000, do_oe_out);
      base = oe_cnt;
      u_host.frame(16'h0000, 16, v);
      chk("oe_disarmed", 16'h0000, oe_cnt != base);
      $display("test mid reset done");
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in) nrst_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      t_reset;
      t_three;
      t_port;
      t_flash;
      t_reset_cmd;
      t_midreset;
      summarize;
   end
   // The flash program wait dominates a run of about 120 us; the limit leaves ample room.
   initial begin
      #400000;
      err_total++;
      $display("MISMATCH watchdog expected done seen timeout");
      summarize;
   end
endmodule
bind spsp_top spsp_top_asserts u_chk (
   .clk_sys_in                   (clk_sys_in),
   .nrst_in                      (nrst_in),
   .cs_n_in                      (cs_n_in),
   .sclk_in                      (sclk_in),
   .di_in                        (di_in),
   .do_out                       (do_out),
   .do_oe_out                    (do_oe_out),
   .four_wire_out                (four_wire_out),
   .flash_write_power_enable_out (flash_write_power_enable_out),
   .port_wr_out                  (port_wr_out),
   .port_addr_out                (port_addr_out),
   .port_data_out                (port_data_out)
);
